// ---- core/samc_pkg.sv ----
// Shared constants, timing counts and state encoding for the converter control
package samc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_HOLD_INTERVAL_NS = 50;
  // Least time, rounded up to whole system clock cycles
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_COUNT_WIDTH = 8;
  localparam logic [HOLD_COUNT_WIDTH-1:0] HOLD_COUNT_LAST = HOLD_COUNT_WIDTH'(RESET_HOLD_CYCLES - 1);
  localparam logic [HOLD_COUNT_WIDTH-1:0] HOLD_COUNT_ZERO = 8'h00;

  // ==========================================================
  // Variants and assignment word
  localparam int VARIANT_EIGHT = 8;
  localparam int VARIANT_FOUR = 4;
  localparam int VARIANT_ONE = 1;
  localparam int WORD_BITS_EIGHT = 4;
  localparam int WORD_BITS_FOUR = 3;
  // Assignment word layout: single_or_pair_choice, odd_sign, select1, select0
  localparam int WORD_SINGLE_BIT = 3;
  localparam int WORD_ODD_BIT = 2;
  localparam int WORD_SEL1_BIT = 1;
  localparam int WORD_SEL0_BIT = 0;
  localparam logic [3:0] WORD_RESET = 4'h0;

  // ==========================================================
  // Result and successive approximation
  localparam int RESULT_BITS = 8;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] TRIAL_FIRST = 8'h80;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [2:0] BIT_LSB = 3'h0;
  localparam logic [2:0] BIT_FIRST_REVERSED = 3'h1;
  localparam logic [1:0] COUNT_ZERO = 2'h0;
  localparam logic [2:0] CHANNEL_ZERO = 3'h0;
  localparam logic [2:0] CHANNEL_ONE = 3'h1;

  typedef enum logic [2:0] {
    SAMC_IDLE = 3'b000,
    SAMC_ADDRESS = 3'b001,
    SAMC_SAMPLE = 3'b010,
    SAMC_CONVERT = 3'b011,
    SAMC_REVERSED = 3'b100,
    SAMC_HOLD = 3'b101
  } samc_state_type;

endpackage

// ---- core/samc_edge_detect.sv ----
// Rising and falling edge pulses of a synchronous level input
`timescale 1ns/1ps

module samc_edge_detect
  import samc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic level,
  output logic rise,
  output logic fall
);

  logic last_level;
  logic next_last_level;

  always_comb
  begin
    next_last_level = level;
    rise = level & ~last_level;
    fall = ~level & last_level;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      last_level <= 1'b0;
    end
    else
    begin
      last_level <= next_last_level;
    end
  end

endmodule

// ---- core/samc_control.sv ----
// Serial addressing, multiplexer selection and result sequencing of the converter
`timescale 1ns/1ps

module samc_control
  import samc_pkg::*;
#(
  parameter int VARIANT_CHANNELS = VARIANT_EIGHT
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in_line,
  input wire logic comp_above,
  output logic serial_out,
  output logic serial_out_oe,
  output logic conversion_in_progress,
  output logic conversion_in_progress_oe,
  output logic track_enable,
  output logic [2:0] mux_pos_channel,
  output logic [2:0] mux_neg_channel,
  output logic mux_neg_common,
  output logic [7:0] dac_code,
  output logic [7:0] result_code
);

  localparam int WORD_BITS = (VARIANT_CHANNELS == VARIANT_EIGHT) ? WORD_BITS_EIGHT : WORD_BITS_FOUR;
  localparam logic [1:0] WORD_COUNT_LAST = 2'(WORD_BITS - 1);
  localparam logic HAS_REVERSED = (VARIANT_CHANNELS != VARIANT_ONE);

  // ==========================================================
  // Serial clock edges
  logic clock_rise;
  logic clock_fall;

  samc_edge_detect edge_unit (
    .clk_sys(clk_sys),
    .reset(reset),
    .level(serial_clock),
    .rise(clock_rise),
    .fall(clock_fall)
  );

  // ==========================================================
  // Hold-reset detector
  logic [HOLD_COUNT_WIDTH-1:0] hold_count;
  logic [HOLD_COUNT_WIDTH-1:0] next_hold_count;
  logic hold_reset;

  always_comb
  begin
    next_hold_count = HOLD_COUNT_ZERO;
    hold_reset = 1'b0;
    if (serial_clock && chip_select_n)
    begin
      if (hold_count == HOLD_COUNT_LAST)
      begin
        hold_reset = 1'b1;
        next_hold_count = hold_count;
      end
      else
      begin
        next_hold_count = hold_count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      hold_count <= HOLD_COUNT_ZERO;
    end
    else
    begin
      hold_count <= next_hold_count;
    end
  end

  // ==========================================================
  // Sequencer
  samc_state_type state;
  samc_state_type next_state;
  logic [2:0] word_shift;
  logic [2:0] next_word_shift;
  logic [1:0] word_count;
  logic [1:0] next_word_count;
  logic [3:0] word;
  logic [3:0] next_word;
  logic [3:0] full_word;
  logic [2:0] bit_index;
  logic [2:0] next_bit_index;
  logic [7:0] next_dac_code;
  logic [7:0] next_result_code;
  logic next_serial_out;
  logic [2:0] next_mux_pos_channel;
  logic [2:0] next_mux_neg_channel;
  logic next_mux_neg_common;
  logic [2:0] pair_base;
  logic [2:0] chosen_channel;

  always_comb
  begin
    next_state = state;
    next_word_shift = word_shift;
    next_word_count = word_count;
    next_word = word;
    next_bit_index = bit_index;
    next_dac_code = dac_code;
    next_result_code = result_code;
    next_serial_out = serial_out;
    next_mux_pos_channel = mux_pos_channel;
    next_mux_neg_channel = mux_neg_channel;
    next_mux_neg_common = mux_neg_common;

    // Normalise the shifted word to the four-bit layout
    if (WORD_BITS == WORD_BITS_EIGHT)
    begin
      full_word = {word_shift, serial_in_line};
    end
    else
    begin
      full_word = {word_shift[1:0], serial_in_line, 1'b0};
    end

    // Channel decode from the freshly completed word
    if (VARIANT_CHANNELS == VARIANT_EIGHT)
    begin
      chosen_channel = {full_word[WORD_SEL1_BIT], full_word[WORD_SEL0_BIT], full_word[WORD_ODD_BIT]};
      pair_base = {full_word[WORD_SEL1_BIT], full_word[WORD_SEL0_BIT], 1'b0};
    end
    else
    begin
      chosen_channel = {1'b0, full_word[WORD_SEL1_BIT], full_word[WORD_ODD_BIT]};
      pair_base = {1'b0, full_word[WORD_SEL1_BIT], 1'b0};
    end

    case (state)
      SAMC_IDLE:
      begin
        // Leading zeros are ignored; the first one starts addressing, but the one-channel variant starts sampling on the first rising edge
        if (!chip_select_n && clock_rise)
        begin
          if (!HAS_REVERSED)
          begin
            next_state = SAMC_SAMPLE;
            next_mux_pos_channel = CHANNEL_ZERO;
            next_mux_neg_channel = CHANNEL_ONE;
            next_mux_neg_common = 1'b0;
          end
          else if (serial_in_line)
          begin
            next_state = SAMC_ADDRESS;
            next_word_count = COUNT_ZERO;
            next_word_shift = 3'h0;
          end
        end
      end
      SAMC_ADDRESS:
      begin
        if (clock_rise)
        begin
          next_word_shift = {word_shift[1:0], serial_in_line};
          next_word_count = word_count + 1'b1;
          if (word_count == WORD_COUNT_LAST)
          begin
            // Latched only here, so the selection is fresh for each conversion
            next_word = full_word;
            next_state = SAMC_SAMPLE;
            if (full_word[WORD_SINGLE_BIT])
            begin
              next_mux_pos_channel = chosen_channel;
              next_mux_neg_channel = CHANNEL_ZERO;
              next_mux_neg_common = 1'b1;
            end
            else if (full_word[WORD_ODD_BIT])
            begin
              next_mux_pos_channel = pair_base | CHANNEL_ONE;
              next_mux_neg_channel = pair_base;
              next_mux_neg_common = 1'b0;
            end
            else
            begin
              next_mux_pos_channel = pair_base;
              next_mux_neg_channel = pair_base | CHANNEL_ONE;
              next_mux_neg_common = 1'b0;
            end
          end
        end
      end
      SAMC_SAMPLE:
      begin
        // Half a serial clock of tracking ends at the falling edge
        if (clock_fall)
        begin
          next_state = SAMC_CONVERT;
          next_serial_out = 1'b0;
          next_bit_index = BIT_MSB;
          next_dac_code = TRIAL_FIRST;
        end
      end
      SAMC_CONVERT:
      begin
        if (clock_fall)
        begin
          // Comparator low on equality yields zero bits, so inverted inputs read all zero
          next_serial_out = comp_above;
          next_result_code[bit_index] = comp_above;
          next_dac_code[bit_index] = comp_above;
          if (bit_index == BIT_LSB)
          begin
            next_bit_index = BIT_FIRST_REVERSED;
            next_state = HAS_REVERSED ? SAMC_REVERSED : SAMC_HOLD;
          end
          else
          begin
            next_dac_code[bit_index - 1'b1] = 1'b1;
            next_bit_index = bit_index - 1'b1;
          end
        end
      end
      SAMC_REVERSED:
      begin
        if (clock_fall)
        begin
          next_serial_out = result_code[bit_index];
          next_bit_index = bit_index + 1'b1;
          if (bit_index == BIT_MSB)
          begin
            next_state = SAMC_HOLD;
          end
        end
      end
      SAMC_HOLD:
      begin
        // Output keeps the last bit until deselect
        next_state = SAMC_HOLD;
      end
      default:
      begin
        next_state = SAMC_IDLE;
      end
    endcase

    // Deselect abandons any sequence in flight
    if (chip_select_n)
    begin
      next_state = SAMC_IDLE;
      next_serial_out = 1'b0;
    end
    if (hold_reset)
    begin
      next_state = SAMC_IDLE;
      next_word = WORD_RESET;
      next_result_code = RESULT_RESET;
      next_dac_code = RESULT_RESET;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state <= SAMC_IDLE;
      word_shift <= 3'h0;
      word_count <= COUNT_ZERO;
      word <= WORD_RESET;
      bit_index <= BIT_MSB;
      dac_code <= RESULT_RESET;
      result_code <= RESULT_RESET;
      serial_out <= 1'b0;
      mux_pos_channel <= CHANNEL_ZERO;
      mux_neg_channel <= CHANNEL_ONE;
      mux_neg_common <= 1'b0;
    end
    else
    begin
      state <= next_state;
      word_shift <= next_word_shift;
      word_count <= next_word_count;
      word <= next_word;
      bit_index <= next_bit_index;
      dac_code <= next_dac_code;
      result_code <= next_result_code;
      serial_out <= next_serial_out;
      mux_pos_channel <= next_mux_pos_channel;
      mux_neg_channel <= next_mux_neg_channel;
      mux_neg_common <= next_mux_neg_common;
    end
  end

  // ==========================================================
  // Pin drive
  always_comb
  begin
    serial_out_oe = (state == SAMC_CONVERT) || (state == SAMC_REVERSED) || (state == SAMC_HOLD);
    conversion_in_progress = (state == SAMC_CONVERT);
    conversion_in_progress_oe = serial_out_oe;
    track_enable = (state == SAMC_SAMPLE);
  end

endmodule

// ---- tb/samc_control_properties.sv ----
// Concurrent checks on the converter control ports
`timescale 1ns/1ps

module samc_control_properties
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in_line,
  input wire logic comp_above,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic conversion_in_progress,
  input wire logic conversion_in_progress_oe,
  input wire logic track_enable,
  input wire logic [2:0] mux_pos_channel,
  input wire logic [2:0] mux_neg_channel,
  input wire logic mux_neg_common,
  input wire logic [7:0] dac_code,
  input wire logic [7:0] result_code
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ==========================================
  // Cycles with clock and deselect both high
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  always_comb
  begin
    next_hold_cnt = hold_cnt;
    if (!(serial_clock && chip_select_n))
      next_hold_cnt = 4'h0;
    else if (hold_cnt != 4'hF)
      next_hold_cnt = hold_cnt + 4'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      hold_cnt <= 4'h0;
    else
      hold_cnt <= next_hold_cnt;
  end

  // ==========================================
  // Assertions and covers
  a_pin_reset_clears: assert property (hold_cnt == 4'hF |-> result_code == 8'h00 && dac_code == 8'h00)
    else $error("pin reset left result");
  a_deselect_releases: assert property (chip_select_n [*2] |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_busy_ends_driven: assert property ($fell(conversion_in_progress) && !chip_select_n |-> serial_out_oe)
    else $error("output released after last decision");
  a_mux_word_frozen: assert property (conversion_in_progress |-> $stable(mux_pos_channel) &&
    $stable(mux_neg_channel) && $stable(mux_neg_common))
    else $error("selection moved in conversion");
  a_pair_adjacent: assert property (conversion_in_progress && !mux_neg_common |->
    mux_neg_channel == (mux_pos_channel ^ 3'h1))
    else $error("pair not adjacent");
  a_leading_zero: assert property ($rose(serial_out_oe) |-> !serial_out && conversion_in_progress)
    else $error("no leading zero");
  a_track_before_drive: assert property ($fell(track_enable) && !chip_select_n |->
    conversion_in_progress && serial_out_oe && !serial_out)
    else $error("no conversion after tracking");
  a_busy_pin_driven: assert property (conversion_in_progress |-> conversion_in_progress_oe)
    else $error("busy not driven");

  c_track: cover property ($rose(track_enable));
  c_pin_reset: cover property (hold_cnt == 4'hF);
  c_busy_done: cover property ($fell(conversion_in_progress) && serial_out_oe);
  c_hold_high: cover property (!conversion_in_progress && serial_out_oe && serial_out);
endmodule

bind samc_control samc_control_properties i_props (.clk_sys(clk_sys), .reset(reset),
  .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in_line(serial_in_line),
  .comp_above(comp_above), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .conversion_in_progress(conversion_in_progress), .conversion_in_progress_oe(conversion_in_progress_oe),
  .track_enable(track_enable), .mux_pos_channel(mux_pos_channel), .mux_neg_channel(mux_neg_channel),
  .mux_neg_common(mux_neg_common), .dac_code(dac_code), .result_code(result_code));

// ---- tb/samc_analog_model.sv ----
// Analog input levels and comparator facing the converter control
`timescale 1ns/1ps

module samc_analog_model
(
  input wire logic [2:0] mux_pos_channel,
  input wire logic [2:0] mux_neg_channel,
  input wire logic mux_neg_common,
  input wire logic [7:0] dac_code,
  output logic comp_above
);
  // Levels rise with channel, common sits lowest
  logic signed [9:0] diff;
  always_comb
  begin
    diff = $signed({3'h0, mux_pos_channel, 4'h5}) -
      (mux_neg_common ? 10'sh003 : $signed({3'h0, mux_neg_channel, 4'h5}));
    // Equality counts as not above
    comp_above = diff > $signed({2'h0, dac_code});
  end
endmodule

// ---- tb/samc_control_bench.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ps

module samc_control_bench;
  import samc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic serial_clock = 1'b0;
  logic chip_select_n = 1'b1;
  logic serial_in_line = 1'b0;
  logic comp_above, serial_out, serial_out_oe, busy, busy_oe, track_enable, mux_neg_common;
  logic [2:0] mux_pos_channel, mux_neg_channel;
  logic [7:0] dac_code, result_code;
  logic [16:0] got;
  logic cs_one_n = 1'b1;
  logic one_cmp, one_out, one_oe, one_busy, one_common;
  logic [2:0] one_pos, one_neg;
  logic [7:0] one_dac, one_result;
  int errors = 0;
  int checked = 0;

  samc_control #(.VARIANT_CHANNELS(8)) i_dut (.clk_sys(clk_sys), .reset(reset),
    .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in_line(serial_in_line),
    .comp_above(comp_above), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .conversion_in_progress(busy), .conversion_in_progress_oe(busy_oe), .track_enable(track_enable),
    .mux_pos_channel(mux_pos_channel), .mux_neg_channel(mux_neg_channel),
    .mux_neg_common(mux_neg_common), .dac_code(dac_code), .result_code(result_code));
  samc_analog_model i_model (.mux_pos_channel(mux_pos_channel), .mux_neg_channel(mux_neg_channel),
    .mux_neg_common(mux_neg_common), .dac_code(dac_code), .comp_above(comp_above));
  samc_control #(.VARIANT_CHANNELS(VARIANT_ONE)) i_dut_one (.clk_sys(clk_sys), .reset(reset),
    .serial_clock(serial_clock), .chip_select_n(cs_one_n), .serial_in_line(serial_in_line),
    .comp_above(one_cmp), .serial_out(one_out), .serial_out_oe(one_oe),
    .conversion_in_progress(one_busy), .conversion_in_progress_oe(), .track_enable(),
    .mux_pos_channel(one_pos), .mux_neg_channel(one_neg), .mux_neg_common(one_common),
    .dac_code(one_dac), .result_code(one_result));
  // Pair crossed so the fixed pair sees a positive difference of 16
  samc_analog_model i_model_one (.mux_pos_channel(one_neg), .mux_neg_channel(one_pos),
    .mux_neg_common(one_common), .dac_code(one_dac), .comp_above(one_cmp));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Access tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One serial period; output sampled late in the low half
  task automatic per(input logic b);
    serial_in_line = b;
    serial_clock = 1'b0;
    cyc(4);
    // Both units share one data line; only the driving one counts
    got = {got[15:0], (serial_out_oe & serial_out) | (one_oe & one_out)};
    serial_clock = 1'b1;
    cyc(4);
  endtask

  task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  // Strict comparator loses one code above zero
  function automatic logic [7:0] want(input logic [3:0] w);
    int d;
    d = {w[1:0], w[2], 4'h5} - (w[3] ? 3 : {w[1:0], ~w[2], 4'h5});
    return d > 0 ? 8'(d - 1) : 8'h00;
  endfunction

  // Fewer than 8 periods after the word abandon the conversion (the closing clock fall decides bit 0); fewer than 16 cut the output stream short
  task automatic conv(input logic [3:0] w, input int n);
    logic [7:0] r;
    logic [16:0] e;
    r = want(w);
    e = {8'h00, 1'b0, r};
    for (int i = 1; i < 8; i++) e = {e[15:0], r[i]};
    e = {e[15:0], r[7]};
    chip_select_n = 1'b0;
    per(1'b1);
    for (int i = 3; i >= 0; i--) per(w[i]);
    got = 17'h0;
    for (int i = 0; i < n; i++) per(1'b1);
    if (n == 17)
    begin
      check(got, e, "stream");
      check({9'h0, result_code}, {9'h0, r}, "result");
    end
    check({14'h0, mux_pos_channel}, {14'h0, w[1:0], w[2]}, "pos");
    check({16'h0, mux_neg_common}, {16'h0, w[3]}, "common");
    if (!w[3])
      check({14'h0, mux_neg_channel}, {14'h0, w[1:0], ~w[2]}, "neg");
    serial_clock = 1'b0;
    cyc(2);
    chip_select_n = 1'b1;
    cyc(3);
    check({15'h0, serial_out_oe, busy}, 17'h0, "release");
  endtask

  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial
  begin
    cyc(10);
    reset = 1'b0;
    cyc(2);
    conv(4'hB, 3);
    $display("test abort done");
    for (int w = 0; w < 16; w++) conv(4'(w), 17);
    $display("test mux table done");
    serial_clock = 1'b1;
    cyc(20);
    check({9'h0, result_code}, 17'h0, "pin reset");
    serial_clock = 1'b0;
    $display("test pin reset done");
    // One-channel unit: no start bit, MSB first only, bit 0 held
    cs_one_n = 1'b0;
    got = 17'h0;
    for (int i = 0; i < 14; i++) per(1'b0);
    check(got, 17'h000FF, "one stream");
    check({9'h0, one_result}, 17'h0000F, "one result");
    serial_clock = 1'b0;
    cyc(2);
    cs_one_n = 1'b1;
    cyc(3);
    check({15'h0, one_oe, one_busy}, 17'h0, "one release");
    $display("test one channel done");
    report_and_stop();
  end

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
endmodule
